/* shared/phy_mmd_regs_pkg.sv */
/*
 * Constants for the per-port PHY management register bank: register
 * offsets, field positions, reset values and MMD operation modes.
 * Assumes a 16-bit register space reached through a plain strobe port.
 */
package phy_mmd_regs_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;

	// Offsets follow the PHY register numbers; bank-local ones sit above them.
	localparam logic [7:0] OFF_PARTNER_NP = 8'h08;
	localparam logic [7:0] OFF_MMD_SETUP = 8'h0D;
	localparam logic [7:0] OFF_MMD_DATA = 8'h0E;
	localparam logic [7:0] OFF_LOOPBACK = 8'h11;
	localparam logic [7:0] OFF_PMA_STATUS = 8'h13;
	localparam logic [7:0] OFF_SYMERR_CNT = 8'h15;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h21;
	localparam logic [7:0] OFF_MMD_REGADDR = 8'h22;

	localparam int unsigned NP_NEXT_BIT = 15;
	localparam int unsigned NP_ACK_BIT = 14;
	localparam int unsigned NP_MSG_BIT = 13;
	localparam int unsigned NP_ACK2_BIT = 12;
	localparam int unsigned NP_TOGGLE_BIT = 11;
	localparam int unsigned NP_FIELD_W = 11;

	localparam int unsigned MODE_HI = 15;
	localparam int unsigned MODE_LO = 14;
	localparam int unsigned DEVAD_HI = 4;
	localparam int unsigned DEVAD_LO = 0;
	localparam int unsigned LOOP_BIT = 8;

	localparam logic [15:0] MMD_SETUP_RST = 16'h0000;
	localparam logic [15:0] MMD_DATA_RST = 16'h0000;
	localparam logic [15:0] LOOPBACK_RST = 16'h00F4;
	localparam logic [15:0] SYMERR_RST = 16'h0000;
	localparam logic [15:0] SYMERR_MAX = 16'hFFFF;

	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_PAGE = 0;
	localparam int unsigned IRQ_SYMERR = 1;
	localparam int unsigned IRQ_SATURATE = 2;

	typedef enum logic [1:0] {
		MODE_REGISTER = 2'b00,
		MODE_DATA_NOINC = 2'b01,
		MODE_DATA_INC_RW = 2'b10,
		MODE_DATA_INC_WR = 2'b11
	} mmd_mode_e;
endpackage

/* rtl/phy_mmd_regs.sv */
/*
 * Per-port PHY management register bank: partner next-page word, indirect
 * MMD access pair, remote loopback control, link status and a receive
 * symbol-error frame counter, plus a small sticky interrupt block.
 * Assumes PHY-side inputs are asynchronous to i_core_clk, the MMD target
 * answers reads combinationally, and a plain one-cycle strobe master.
 */
// Summary of operation
// - Bit 15 of the partner next-page word shows the partner's next-page flag, read-only.
// - Bit 14 shows whether the partner's link word was received.
// - Bit 12 shows the partner's second acknowledge.
// - Bit 11 shows the partner's toggle bit as received.
// - Bits 15:14 of the MMD setup register select how the MMD data register is used.
// - Mode 01 makes data accesses without advancing the register address.
// - Mode 10 advances the register address after every data read and write.
// - Mode 11 advances the register address after data writes only.
// - Bits 4:0 of the MMD setup register name the target MMD device and reset to zero.
// - Mode 00 makes the data register carry the register address inside the MMD.
// - Any other mode makes the data register carry the data at the selected address.
// - Loopback bit 8 returns received data out of the same port's transmit pair.
// - A 16-bit counter counts frames with symbol errors and clears when read.
`timescale 1ns/100ps
`default_nettype none
module phy_mmd_regs
	import phy_mmd_regs_pkg::*;
(
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_resetn,
	// Register port.
	input wire logic [phy_mmd_regs_pkg::ADDR_W-1:0] i_addr,
	input wire logic [phy_mmd_regs_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [phy_mmd_regs_pkg::DATA_W-1:0] o_rdata,
	// PHY side, asynchronous to the core clock.
	input wire logic [15:0] i_partner_np_word,
	input wire logic i_partner_np_valid,
	input wire logic i_link_up,
	input wire logic i_rx_symerr_frame,
	// MMD target port.
	output logic [4:0] o_mmd_devad,
	output logic [15:0] o_mmd_regaddr,
	output logic [15:0] o_mmd_wdata,
	output logic o_mmd_wr,
	output logic o_mmd_rd,
	input wire logic [15:0] i_mmd_rdata,
	// Loopback control and interrupt.
	output logic o_remote_loopback,
	output logic o_irq
);
	import phy_mmd_regs_pkg::*;

	logic rst_sync1_q;
	logic rst_n;
	logic [15:0] np_s1_q, np_s2_q, np_word_q;
	logic [1:0] npv_s_q;
	logic npv_d1_q;
	logic [1:0] link_s_q;
	logic [1:0] err_s_q;
	logic err_d1_q;
	logic [15:0] setup_q;
	logic [15:0] regaddr_q;
	logic [15:0] loop_q;
	logic [15:0] symerr_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
	logic [15:0] rdata_q;
	logic page_evt, err_evt, sat_evt;
	logic data_wr, data_rd, mmd_data_mode, adv;
	mmd_mode_e mode;

	// Reset release through two flops; assert is asynchronous.
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_n <= rst_sync1_q;
		end
	end

	// Two-flop synchronisers. The page word is only captured on the rising
	// edge of its valid flag, so by then the word bus has settled.
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			np_s1_q <= 16'h0000;
			np_s2_q <= 16'h0000;
			npv_s_q <= 2'b00;
			npv_d1_q <= 1'b0;
			link_s_q <= 2'b00;
			err_s_q <= 2'b00;
			err_d1_q <= 1'b0;
		end else begin
			np_s1_q <= i_partner_np_word;
			np_s2_q <= np_s1_q;
			npv_s_q <= {npv_s_q[0], i_partner_np_valid};
			npv_d1_q <= npv_s_q[1];
			link_s_q <= {link_s_q[0], i_link_up};
			err_s_q <= {err_s_q[0], i_rx_symerr_frame};
			err_d1_q <= err_s_q[1];
		end
	end

	assign page_evt = npv_s_q[1] & ~npv_d1_q;
	assign err_evt = err_s_q[1] & ~err_d1_q;

	// Partner page word held as received; all fields read-only.
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			np_word_q <= 16'h0000;
		end else if (page_evt) begin
			np_word_q <= np_s2_q;
		end
	end

	// MMD access decode.
	assign mode = mmd_mode_e'(setup_q[MODE_HI:MODE_LO]);
	assign mmd_data_mode = (mode != MODE_REGISTER);
	assign data_wr = i_wr && (i_addr == OFF_MMD_DATA);
	assign data_rd = i_rd && (i_addr == OFF_MMD_DATA);

	always_comb begin
		unique case (mode)
			MODE_REGISTER: adv = 1'b0;
			MODE_DATA_NOINC: adv = 1'b0;
			MODE_DATA_INC_RW: adv = data_wr | data_rd;
			MODE_DATA_INC_WR: adv = data_wr;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_q <= MMD_SETUP_RST;
		end else if (i_wr && i_addr == OFF_MMD_SETUP) begin
			setup_q <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			regaddr_q <= MMD_DATA_RST;
		end else if (data_wr && !mmd_data_mode) begin
			regaddr_q <= i_wdata;
		end else if (adv) begin
			regaddr_q <= regaddr_q + 16'h0001;
		end
	end

	assign o_mmd_devad = setup_q[DEVAD_HI:DEVAD_LO];
	assign o_mmd_regaddr = regaddr_q;
	assign o_mmd_wdata = i_wdata;
	assign o_mmd_wr = data_wr && mmd_data_mode;
	assign o_mmd_rd = data_rd && mmd_data_mode;

	// Remote loopback control.
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			loop_q <= LOOPBACK_RST;
		end else if (i_wr && i_addr == OFF_LOOPBACK) begin
			loop_q <= {i_wdata[15:1], 1'b0};
		end
	end

	assign o_remote_loopback = loop_q[LOOP_BIT];

	// Symbol-error frame counter. A new error in the read cycle counts as
	// one so that no frame is lost across the clear.
	assign sat_evt = err_evt && (symerr_q == SYMERR_MAX);

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			symerr_q <= SYMERR_RST;
		end else if (i_rd && i_addr == OFF_SYMERR_CNT) begin
			symerr_q <= err_evt ? 16'h0001 : 16'h0000;
		end else if (err_evt && symerr_q != SYMERR_MAX) begin
			symerr_q <= symerr_q + 16'h0001;
		end
	end

	// Sticky status, cleared by a read; a set in the same cycle wins.
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_PAGE] = page_evt;
		irq_set[IRQ_SYMERR] = err_evt;
		irq_set[IRQ_SATURATE] = sat_evt;
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (i_rd && i_addr == OFF_IRQ_STATUS) begin
			irq_stat_q <= irq_set;
		end else begin
			irq_stat_q <= irq_stat_q | irq_set;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q <= '0;
		end else if (i_wr && i_addr == OFF_IRQ_MASK) begin
			irq_mask_q <= i_wdata[IRQ_W-1:0];
		end
	end

	assign o_irq = |(irq_stat_q & irq_mask_q);

	// Read data valid in the cycle after the strobe only; unmapped reads zero.
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0000;
		end else if (i_rd) begin
			unique case (i_addr)
				OFF_PARTNER_NP: rdata_q <= np_word_q;
				OFF_MMD_SETUP: rdata_q <= setup_q;
				OFF_MMD_DATA: rdata_q <= mmd_data_mode ? i_mmd_rdata : regaddr_q;
				OFF_LOOPBACK: rdata_q <= loop_q;
				OFF_PMA_STATUS: rdata_q <= {15'h0000, link_s_q[1]};
				OFF_SYMERR_CNT: rdata_q <= symerr_q;
				OFF_IRQ_STATUS: rdata_q <= {{(16-IRQ_W){1'b0}}, irq_stat_q};
				OFF_IRQ_MASK: rdata_q <= {{(16-IRQ_W){1'b0}}, irq_mask_q};
				OFF_MMD_REGADDR: rdata_q <= regaddr_q;
				default: rdata_q <= 16'h0000;
			endcase
		end else begin
			rdata_q <= 16'h0000;
		end
	end

	assign o_rdata = rdata_q;
endmodule
`default_nettype wire

/* bench/phy_mmd_regs_properties.sv */
/* Port-level checker for phy_mmd_regs, bound to it below.
   Assumes one-cycle strobes that are never high together. */
`timescale 1ns/100ps
`default_nettype none
module phy_mmd_regs_chk
	import phy_mmd_regs_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	input wire logic [4:0] o_mmd_devad,
	input wire logic [15:0] o_mmd_regaddr,
	input wire logic [15:0] o_mmd_wdata,
	input wire logic o_mmd_wr,
	input wire logic o_mmd_rd,
	input wire logic [15:0] i_mmd_rdata,
	input wire logic o_remote_loopback
);
	// The mode field is not a port, so it is tracked from setup writes.
	logic [1:0] mode_q;
	logic dw, dr;
	assign dw = i_wr && i_addr == OFF_MMD_DATA;
	assign dr = i_rd && i_addr == OFF_MMD_DATA;
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_q <= 2'b00;
		end else if (i_wr && i_addr == OFF_MMD_SETUP) begin
			mode_q <= i_wdata[15:14];
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	chk_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
		else $error("read data not idle");
	chk_devad_load: assert property (i_wr && i_addr == OFF_MMD_SETUP
		|=> o_mmd_devad == $past(i_wdata[4:0])) else $error("device address wrong");
	chk_loop_bit: assert property (i_wr && i_addr == OFF_LOOPBACK
		|=> o_remote_loopback == $past(i_wdata[8])) else $error("loopback wrong");
	chk_reg_mode: assert property (dw && mode_q == 2'b00 |-> !o_mmd_wr
		##1 o_mmd_regaddr == $past(i_wdata)) else $error("register mode wrong");
	chk_data_wr: assert property (dw && mode_q != 2'b00
		|-> o_mmd_wr && o_mmd_wdata == i_wdata) else $error("data write missing");
	chk_data_rd: assert property (dr && mode_q != 2'b00 |-> o_mmd_rd
		##1 o_rdata == $past(i_mmd_rdata)) else $error("data read wrong");
	chk_inc_addr: assert property ((dr && mode_q == 2'b10) || (dw && mode_q[1])
		|=> o_mmd_regaddr == $past(o_mmd_regaddr) + 16'h0001) else $error("no increment");
	chk_hold_addr: assert property ((dr && mode_q[0]) || (dw && mode_q == 2'b01)
		|=> $stable(o_mmd_regaddr)) else $error("address moved");
endmodule
bind phy_mmd_regs phy_mmd_regs_chk i_chk(.i_core_clk, .i_resetn, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .o_mmd_devad, .o_mmd_regaddr, .o_mmd_wdata, .o_mmd_wr,
	.o_mmd_rd, .i_mmd_rdata, .o_remote_loopback);
`default_nettype wire

/* bench/phy_mmd_regs_tb.sv */
/* Self-checking bench for phy_mmd_regs.
   Assumes the strobe port contract and 2-clock input synchronisation. */
`timescale 1ns/100ps
`default_nettype none
module phy_mmd_regs_tb;
	import phy_mmd_regs_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_resetn, i_wr, i_rd, i_np_v, i_link_up, i_serr;
	logic [7:0] i_addr;
	logic [15:0] i_wdata, i_np, i_mmd_rdata, o_rdata, o_mmd_regaddr, o_mmd_wdata;
	logic [4:0] o_mmd_devad;
	logic o_mmd_wr, o_mmd_rd, o_remote_loopback, o_irq;
	int n_errors = 0;
	int tests_run = 0;
	always #20 i_core_clk = ~i_core_clk;
	phy_mmd_regs i_phy_mmd_regs(.i_core_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_partner_np_word(i_np), .i_partner_np_valid(i_np_v), .i_link_up,
		.i_rx_symerr_frame(i_serr), .o_mmd_devad, .o_mmd_regaddr, .o_mmd_wdata, .o_mmd_wr,
		.o_mmd_rd, .i_mmd_rdata, .o_remote_loopback, .o_irq);
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic clk(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		clk(1);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		clk(1);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] exp);
		clk(1);
		i_addr <= a;
		i_rd <= 1'b1;
		clk(1);
		i_rd <= 1'b0;
		#1;
		check(nm, o_rdata, exp);
	endtask
	// The interrupt may be registered, so it is looked at two edges on.
	task automatic irqc(input logic exp);
		clk(2);
		#1;
		check("irq", {15'h0000, o_irq}, {15'h0000, exp});
	endtask
	task automatic t_reset();
		rdc("setup", OFF_MMD_SETUP, 16'h0000);
		rdc("data", OFF_MMD_DATA, 16'h0000);
		rdc("loop", OFF_LOOPBACK, LOOPBACK_RST);
		rdc("count", OFF_SYMERR_CNT, 16'h0000);
		rdc("link", OFF_PMA_STATUS, 16'h0001);
		rdc("unmapped", 8'h40, 16'h0000);
	endtask
	task automatic t_mmd();
		logic [15:0] ra;
		ra = 16'h1230;
		wr(OFF_MMD_SETUP, 16'h0005);
		wr(OFF_MMD_DATA, ra);
		check("devad", {11'h000, o_mmd_devad}, 16'h0005);
		rdc("mode00", OFF_MMD_DATA, ra);
		i_mmd_rdata <= 16'hBEEF;
		for (int m = 1; m < 4; m++) begin
			wr(OFF_MMD_SETUP, {m[1:0], 14'h0005});
			rdc("mode data", OFF_MMD_DATA, 16'hBEEF);
			ra = ra + 16'(m == 2);
			check("rd addr", o_mmd_regaddr, ra);
			wr(OFF_MMD_DATA, 16'h0042);
			ra = ra + 16'(m != 1);
			check("wr addr", o_mmd_regaddr, ra);
		end
		rdc("regaddr", OFF_MMD_REGADDR, ra);
		rdc("setup rb", OFF_MMD_SETUP, 16'hC005);
	endtask
	task automatic t_page();
		logic [15:0] w;
		wr(OFF_IRQ_MASK, 16'h0001);
		for (int i = 0; i < 2; i++) begin
			w = i ? 16'h2755 : 16'hD8A5;
			clk(1);
			i_np_v <= 1'b0;
			i_np <= w;
			clk(4);
			i_np_v <= 1'b1;
			// Two synchroniser flops plus the sticky status flop put the
			// interrupt three edges after the valid flag rises.
			clk(1);
			irqc(1'b1);
			clk(4);
			wr(OFF_PARTNER_NP, 16'hFFFF);
			rdc("np word", OFF_PARTNER_NP, w);
			rdc("page st", OFF_IRQ_STATUS, 16'h0001);
			irqc(1'b0);
		end
	endtask
	task automatic t_symerr();
		wr(OFF_IRQ_MASK, 16'h0000);
		repeat (3) begin
			clk(1);
			i_serr <= 1'b1;
			clk(3);
			i_serr <= 1'b0;
			clk(3);
		end
		irqc(1'b0);
		wr(OFF_IRQ_MASK, 16'h0002);
		irqc(1'b1);
		rdc("err st", OFF_IRQ_STATUS, 16'h0002);
		irqc(1'b0);
		rdc("count", OFF_SYMERR_CNT, 16'h0003);
		rdc("count clr", OFF_SYMERR_CNT, 16'h0000);
	endtask
	task automatic t_loop();
		wr(OFF_LOOPBACK, 16'h0101);
		check("loop on", {15'h0000, o_remote_loopback}, 16'h0001);
		rdc("loop rb", OFF_LOOPBACK, 16'h0100);
		wr(OFF_LOOPBACK, 16'h00F4);
		check("loop off", {15'h0000, o_remote_loopback}, 16'h0000);
	endtask
	task automatic final_report();
		$display("mismatches %0d, comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		{i_resetn, i_wr, i_rd, i_np_v, i_serr, i_addr, i_wdata, i_np, i_mmd_rdata} = '0;
		i_link_up = 1'b1;
		clk(16);
		i_resetn <= 1'b1;
		clk(3);
		t_reset();
		t_mmd();
		t_page();
		t_symerr();
		t_loop();
		final_report();
	end
	initial begin
		#200000;
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
